// *** design/channel_status_buffer.sv ***
`timescale 1ns/1ps
// What this block does
// - Stores five status bytes per channel, eighty bits in all.
// - Earliest received status bit lands in each byte's most significant bit.
// - Channel A byte zero reads at address 19h, top bit is pro/consumer.
// - Capture buffer fills bit by bit with the status bits of frames 0 to 39 of each block.
// - Host buffer loads only whole blocks from the capture buffer.
// - Host buffer is readable through the control port register space.
// - Serial stream goes to a chosen output pin in software mode, dedicated pin otherwise.
// - Serial stream advances one bit on each output frame clock edge while data waits.
// - With its enable set, each block transfer raises an interrupt.
// - Inhibit bit in second control register 02h stops block transfers.
// - Transfers come about one block, 192 frames, apart.
module channel_status_buffer
   import cstat_pkg::*;
(
   // Clock, reset and clock enable
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Mode strap level
   input wire logic hardware_mode_in,
   // Decoded receiver status bits
   input wire logic rx_bit_valid_in,
   input wire logic rx_cbit_in,
   input wire logic rx_chan_b_in,
   input wire logic rx_block_start_in,
   // Output frame timing
   input wire logic output_frame_clock_in,
   // Control port
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Pins
   output logic cstat_serial_out,
   output logic [OUT_PIN_COUNT-1:0] general_purpose_output_out,
   output logic irq_out,
   output logic rx_ready_out
);

   typedef struct packed {
      capture_state_e cap;
      logic [7:0] frame;
      logic [BUF_BYTES-1:0][7:0] dbuf;
      logic xfer_pend;
      logic [7:0] second_control;
      logic [7:0] int_enable;
      logic [7:0] pin_route;
      logic int_status;
      logic flag_snap;
      logic irq;
      logic ofc_prev;
      logic ser;
      logic cstat_pin;
      logic [OUT_PIN_COUNT-1:0] gp_out;
      logic rd_stage;
      logic [6:0] rd_addr;
      logic [7:0] rdata;
      logic rvalid;
      logic rx_ready;
   } top_state_s;

   top_state_s st;
   top_state_s next_st;

   bit_stream_if #(.WIDTH(FIFO_WIDTH)) stream_bus();

   logic [7:0] mem_rd_data;
   logic [3:0] mem_rd_index;
   logic ofc_edge;
   logic inhibit;
   logic [3:0] byte_index;
   logic [2:0] bit_pos;
   logic in_capture_window;
   logic status_addr_hit;
   logic [6:0] status_offset;
   logic [1:0] route_sel;

   // Outputs come straight from the state register.
   assign reg_rdata_out = st.rdata;
   assign reg_rvalid_out = st.rvalid;
   assign cstat_serial_out = st.cstat_pin;
   assign general_purpose_output_out = st.gp_out;
   assign irq_out = st.irq;
   assign rx_ready_out = st.rx_ready;

   // Every decoded bit enters the serial stream FIFO; a full FIFO drops the bit
   // rather than stalling the receiver, which cannot be held back.
   assign stream_bus.push_valid = rx_bit_valid_in;
   assign stream_bus.push_data = rx_cbit_in;

   // One pop per output frame clock edge, rising or falling.
   assign ofc_edge = (output_frame_clock_in != st.ofc_prev);
   assign stream_bus.pop_ready = ofc_edge;

   assign inhibit = st.second_control[INHIBIT_BIT];
   assign route_sel = st.pin_route[PIN_ROUTE_LSB +: 2];

   // Byte and bit position of the current frame's status bit in the capture buffer.
   // Channel B bytes follow the five channel A bytes.
   assign byte_index = rx_chan_b_in ? 4'(4'(CS_BYTES_PER_CHAN) + {1'b0, st.frame[5:3]})
                                    : {1'b0, st.frame[5:3]};
   assign bit_pos = ~st.frame[2:0];
   assign in_capture_window = (st.frame <= LAST_CAPTURE_FRAME);

   // Host buffer address decode; the offset indexes the byte store directly.
   assign status_addr_hit = (reg_addr_in >= ADDR_STATUS_FIRST) &&
                            (reg_addr_in <= ADDR_STATUS_LAST);
   assign status_offset = 7'(reg_addr_in - ADDR_STATUS_FIRST);
   assign mem_rd_index = (reg_rd_in && status_addr_hit) ? status_offset[3:0]
                                                        : NO_BYTE_INDEX;

   // Serial stream storage between receiver and output pin.
   stream_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_stream_fifo (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .bus(stream_bus.store)
   );

   // Host-visible block store, loaded only by a whole-block transfer.
   status_mem u_status_mem (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in),
      .load_in(st.xfer_pend),
      .load_data_in(st.dbuf),
      .rd_index_in(mem_rd_index),
      .rd_data_out(mem_rd_data)
   );

   // Next state of the whole block.
   always_comb begin
      next_st = st;
      next_st.xfer_pend = 1'b0;
      next_st.rvalid = 1'b0;
      next_st.rd_stage = 1'b0;
      next_st.ofc_prev = output_frame_clock_in;
      next_st.rx_ready = stream_bus.push_ready;

      // Capture sequencer. A block start on a channel A bit always restarts the fill, so a block
      // cut short by a new start is thrown away and never reaches the host.
      if (rx_bit_valid_in) begin
         if (rx_block_start_in && !rx_chan_b_in) begin
            next_st.cap = CAP_FILL;
            next_st.frame = 8'h00;
            next_st.dbuf[{1'b0, 3'h0}][3'h7] = rx_cbit_in;
         end else begin
            case (st.cap)
               CAP_HUNT: begin
                  next_st.frame = 8'h00;
               end
               CAP_FILL: begin
                  if (in_capture_window) begin
                     next_st.dbuf[byte_index][bit_pos] = rx_cbit_in;
                  end
                  if (rx_chan_b_in) begin
                     next_st.frame = 8'(st.frame + 1'b1);
                     if (st.frame == LAST_CAPTURE_FRAME) begin
                        // Block complete: copy it out unless the host holds it off.
                        // While inhibited the host buffer keeps its old block and
                        // the next complete block goes through once cleared.
                        next_st.cap = CAP_WAIT;
                        if (!inhibit) begin
                           next_st.xfer_pend = 1'b1;
                        end
                     end
                  end
               end
               CAP_WAIT: begin
                  // Remaining frames of the block carry nothing we store.
                  if (rx_chan_b_in) begin
                     if (st.frame == LAST_FRAME) begin
                        next_st.cap = CAP_HUNT;
                        next_st.frame = 8'h00;
                     end else begin
                        next_st.frame = 8'(st.frame + 1'b1);
                     end
                  end
               end
               default: begin
                  next_st.cap = CAP_HUNT;
                  next_st.frame = 8'h00;
               end
            endcase
         end
      end

      // Serial output bit: a new bit on each frame clock edge while data waits;
      // an underrun holds the previous bit rather than inventing one.
      if (ofc_edge && stream_bus.pop_valid) begin
         next_st.ser = stream_bus.pop_data[0];
      end

      // Pin routing: the dedicated pin in hardware mode, one chosen output pin otherwise.
      next_st.cstat_pin = hardware_mode_in ? next_st.ser : 1'b0;
      for (int i = 0; i < OUT_PIN_COUNT; i++) begin
         next_st.gp_out[i] = !hardware_mode_in && (route_sel == 2'(i + 1)) &&
                          next_st.ser;
      end

      // Register writes; read-only addresses and unknown ones are ignored.
      if (reg_wr_in) begin
         case (reg_addr_in)
            ADDR_SECOND_CONTROL: begin
               next_st.second_control = reg_wdata_in;
            end
            ADDR_INT_ENABLE: begin
               next_st.int_enable = reg_wdata_in;
            end
            ADDR_PIN_ROUTE: begin
               next_st.pin_route = reg_wdata_in;
            end
            default: begin
            end
         endcase
      end

      // Transfer flag clears on read of its register, but a transfer in the
      // same cycle wins so no event is lost.
      if (reg_rd_in && (reg_addr_in == ADDR_INT_STATUS)) begin
         next_st.int_status = 1'b0;
      end
      if (next_st.xfer_pend) begin
         next_st.int_status = 1'b1;
      end
      next_st.irq = next_st.int_status && st.int_enable[XFER_INT_BIT];

      // Reads take two cycles: the byte store answers from a register first,
      // then the result is registered again onto the port.
      if (reg_rd_in) begin
         next_st.rd_stage = 1'b1;
         next_st.rd_addr = reg_addr_in;
         // The flag is captured at the take, before its clear lands.
         next_st.flag_snap = st.int_status;
      end
      if (st.rd_stage) begin
         next_st.rvalid = 1'b1;
         if ((st.rd_addr >= ADDR_STATUS_FIRST) && (st.rd_addr <= ADDR_STATUS_LAST)) begin
            next_st.rdata = mem_rd_data;
         end else begin
            case (st.rd_addr)
               ADDR_SECOND_CONTROL: next_st.rdata = st.second_control;
               ADDR_INT_ENABLE: next_st.rdata = st.int_enable;
               ADDR_PIN_ROUTE: next_st.rdata = st.pin_route;
               // The answer carries the flag as it stood when the read was taken.
               ADDR_INT_STATUS: next_st.rdata = {7'h00, st.flag_snap};
               default: next_st.rdata = 8'h00;
            endcase
         end
      end
   end

   // State register; everything freezes while the clock enable is low.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
         st.cap <= CAP_HUNT;
         st.second_control <= SECOND_CONTROL_RESET;
         st.int_enable <= INT_ENABLE_RESET;
         st.pin_route <= PIN_ROUTE_RESET;
      end else if (clk_en_in) begin
         st <= next_st;
      end
   end
endmodule : channel_status_buffer

// *** design/cstat_pkg.sv ***
// Shared constants for the channel status buffer block.
package cstat_pkg;

   // Buffer geometry: five status bytes for each of the two subframe channels.
   localparam int CS_BYTES_PER_CHAN = 5;
   localparam int NUM_CHANS = 2;
   localparam int BUF_BYTES = CS_BYTES_PER_CHAN * NUM_CHANS;
   localparam int STORED_BITS = BUF_BYTES * 8;

   // Frame counts within one status block.
   localparam logic [7:0] BLOCK_FRAMES = 8'hc0;
   localparam logic [7:0] LAST_FRAME = 8'hbf;
   localparam logic [7:0] LAST_CAPTURE_FRAME = 8'h27;

   // Serial stream buffering.
   localparam int FIFO_WIDTH = 1;
   localparam int FIFO_DEPTH = 16;
   localparam int OUT_PIN_COUNT = 3;

   // Register offsets on the control port.
   localparam logic [6:0] ADDR_SECOND_CONTROL = 7'h02;
   localparam logic [6:0] ADDR_INT_ENABLE = 7'h04;
   localparam logic [6:0] ADDR_PIN_ROUTE = 7'h09;
   localparam logic [6:0] ADDR_INT_STATUS = 7'h0c;
   localparam logic [6:0] ADDR_STATUS_FIRST = 7'h19;
   localparam logic [6:0] ADDR_STATUS_LAST = 7'h22;

   // Field positions.
   localparam int INHIBIT_BIT = 7;
   localparam int XFER_INT_BIT = 0;
   localparam int PIN_ROUTE_LSB = 0;

   // Values after reset, and the byte index used when no status byte is read.
   localparam logic [7:0] SECOND_CONTROL_RESET = 8'h00;
   localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
   localparam logic [7:0] PIN_ROUTE_RESET = 8'h00;
   localparam logic [3:0] NO_BYTE_INDEX = 4'hf;

   // Capture sequencer states.
   typedef enum logic [1:0] {
      CAP_HUNT = 2'b00,
      CAP_FILL = 2'b01,
      CAP_WAIT = 2'b10
   } capture_state_e;

endpackage : cstat_pkg

// *** design/bit_stream_if.sv ***
`timescale 1ns/1ps
// Valid and ready stream between the top and its FIFO.
interface bit_stream_if #(parameter int WIDTH = 1);
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;

   // The storage side takes pushes and offers pops.
   modport store(input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
   // The user side fills and drains.
   modport user(output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface : bit_stream_if

// *** design/stream_fifo.sv ***
`timescale 1ns/1ps
// Small synchronous FIFO; full and empty come from the stored count.
module stream_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   // Clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Stream
   bit_stream_if.store bus
);
   localparam int PTR_W = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] cells;
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [PTR_W:0] count;
   } fifo_state_s;

   fifo_state_s st;
   fifo_state_s next_st;
   logic do_push;
   logic do_pop;

   // Handshake flags straight from the count, so full and empty are exact.
   assign bus.push_ready = (st.count != (PTR_W+1)'(DEPTH));
   assign bus.pop_valid = (st.count != '0);
   assign bus.pop_data = st.cells[st.rptr];

   // Pointer and count update; a push and a pop together leave the count alone.
   always_comb begin
      next_st = st;
      do_push = bus.push_valid && bus.push_ready;
      do_pop = bus.pop_ready && bus.pop_valid;
      if (do_push) begin
         next_st.cells[st.wptr] = bus.push_data;
         next_st.wptr = PTR_W'(st.wptr + 1'b1);
      end
      if (do_pop) begin
         next_st.rptr = PTR_W'(st.rptr + 1'b1);
      end
      if (do_push && !do_pop) begin
         next_st.count = (PTR_W+1)'(st.count + 1'b1);
      end else if (do_pop && !do_push) begin
         next_st.count = (PTR_W+1)'(st.count - 1'b1);
      end
   end

   // State register, frozen while the clock enable is low.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else if (clk_en_in) begin
         st <= next_st;
      end
   end
endmodule : stream_fifo

// *** design/status_mem.sv ***
`timescale 1ns/1ps
// Host-visible status store: loaded whole, read one byte at a time.
module status_mem
   import cstat_pkg::*;
(
   // Clock and control
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Whole-block load
   input wire logic load_in,
   input wire logic [BUF_BYTES-1:0][7:0] load_data_in,
   // Byte read
   input wire logic [3:0] rd_index_in,
   output logic [7:0] rd_data_out
);
   typedef struct packed {
      logic [BUF_BYTES-1:0][7:0] bytes;
      logic [7:0] rd_data;
   } mem_state_s;

   mem_state_s st;
   mem_state_s next_st;

   assign rd_data_out = st.rd_data;

   // A read in the load cycle returns the old block; indices past the end read zero.
   always_comb begin
      next_st = st;
      if (load_in) begin
         next_st.bytes = load_data_in;
      end
      if (rd_index_in < 4'(BUF_BYTES)) begin
         next_st.rd_data = st.bytes[rd_index_in];
      end else begin
         next_st.rd_data = 8'h00;
      end
   end

   // State register.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else if (clk_en_in) begin
         st <= next_st;
      end
   end
endmodule : status_mem

// *** verif/channel_status_buffer_asserts.sv ***
`timescale 1ns/1ps
// Port-level checks for the channel status buffer.
module channel_status_buffer_asserts
   import cstat_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Watched inputs
   input wire logic clk_en_in,
   input wire logic hardware_mode_in,
   input wire logic rx_bit_valid_in,
   input wire logic rx_chan_b_in,
   input wire logic output_frame_clock_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   // Watched outputs
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic cstat_serial_out,
   input wire logic [OUT_PIN_COUNT-1:0] general_purpose_output_out,
   input wire logic irq_out
);
   logic ofc_q;
   logic ofc_edge;
   logic b_bit;
   logic en_wr;
   logic flag_rd;
   // Frame clock history, so either edge counts as a pop request.
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ofc_q <= 1'b0;
      end else begin
         ofc_q <= output_frame_clock_in;
      end
   end
   // Causes that may legally move the outputs.
   assign ofc_edge = output_frame_clock_in != ofc_q;
   assign b_bit = rx_bit_valid_in && rx_chan_b_in && clk_en_in;
   assign en_wr = reg_wr_in && reg_addr_in == ADDR_INT_ENABLE;
   assign flag_rd = reg_rd_in && reg_addr_in == ADDR_INT_STATUS;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_READ_LATENCY: assert property (reg_rd_in && clk_en_in |-> ##2 reg_rvalid_out)
      else $error("read answer late or missing");
   AST_READ_CAUSE: assert property (reg_rvalid_out |-> $past(reg_rd_in, 2))
      else $error("read answer without request");
   AST_RDATA_HOLD: assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
      else $error("read data moved between answers");
   AST_IRQ_RISE: assert property ($rose(irq_out) |->
      $past(b_bit) || $past(b_bit, 2) || $past(en_wr) || $past(en_wr, 2))
      else $error("interrupt rose without a transfer or enable");
   AST_IRQ_FALL: assert property ($fell(irq_out) |->
      $past(flag_rd) || $past(flag_rd, 2) || $past(en_wr) || $past(en_wr, 2))
      else $error("interrupt fell without a clear");
   AST_SERIAL_CAUSE: assert property ($changed(cstat_serial_out) && $past(hardware_mode_in)
      && $past(hardware_mode_in, 2) |-> $past(ofc_edge))
      else $error("status pin moved without a frame clock edge");
   AST_SW_PIN_QUIET: assert property (!$past(hardware_mode_in) |-> !cstat_serial_out)
      else $error("dedicated pin active in software mode");
   AST_HW_PINS_QUIET: assert property ($past(hardware_mode_in) |->
      general_purpose_output_out == {OUT_PIN_COUNT{1'b0}})
      else $error("output pins active in hardware mode");
   AST_PINS_ONEHOT: assert property ($onehot0(general_purpose_output_out))
      else $error("stream routed to more than one pin");
endmodule : channel_status_buffer_asserts

bind channel_status_buffer channel_status_buffer_asserts chk (.ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in), .clk_en_in(clk_en_in), .hardware_mode_in(hardware_mode_in),
   .rx_bit_valid_in(rx_bit_valid_in), .rx_chan_b_in(rx_chan_b_in),
   .output_frame_clock_in(output_frame_clock_in), .reg_addr_in(reg_addr_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .reg_rvalid_out(reg_rvalid_out), .cstat_serial_out(cstat_serial_out),
   .general_purpose_output_out(general_purpose_output_out), .irq_out(irq_out));

// *** verif/host_port_model.sv ***
`timescale 1ns/1ps
// Host side of the control port; each request is held for exactly one taking edge.
module host_port_model (
   // Clock
   input wire logic clk_in,
   // Control port requests
   output logic [6:0] reg_addr_out,
   output logic reg_wr_out,
   output logic reg_rd_out,
   output logic [7:0] reg_wdata_out
);
   // Idle from time zero so the port never floats.
   initial begin
      reg_addr_out = 7'h00;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_wdata_out = 8'h00;
   end
   // A write has no answer; the strobe drops after the taking edge.
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
   endtask : wr
   // Reads drive the address and strobe; the strobe drops after the taking edge.
   task automatic rd(input logic [6:0] a);
      @(posedge clk_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_in);
      reg_rd_out <= 1'b0;
   endtask : rd
endmodule : host_port_model

// *** verif/channel_status_buffer_test.sv ***
`timescale 1ns/1ps
// Self-checking bench: drivers queue expectations, monitors compare.
module channel_status_buffer_test;
   import cstat_pkg::*;
   logic ref_clk_in, rst_n_in, hw_mode, rx_valid, rx_bit, rx_b, rx_start, ofc, wr, rd;
   logic rvalid, ser, irq, rdy, chg, ofc_q, b;
   logic [6:0] addr;
   logic [7:0] wdata, rdata;
   logic [OUT_PIN_COUNT-1:0] gp_pins;
   logic [31:0] seed, rnd;
   logic [15:0] fbits;
   logic [9:0][7:0] img1, img2, junk;
   logic [7:0] rd_q[$];
   logic [7:0] ser_q[$];
   logic [6:0] regs [5] = '{7'h02, 7'h04, 7'h09, 7'h0c, 7'h40};
   int n_errors = 0;
   int n_checks = 0;
   // Free-running clock.
   initial begin
      ref_clk_in = 1'b0;
      forever #4 ref_clk_in = ~ref_clk_in;
   end
   // Clock enable is held high so every request is taken.
   channel_status_buffer uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
      .hardware_mode_in(hw_mode), .rx_bit_valid_in(rx_valid), .rx_cbit_in(rx_bit),
      .rx_chan_b_in(rx_b), .rx_block_start_in(rx_start), .output_frame_clock_in(ofc),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .cstat_serial_out(ser),
      .general_purpose_output_out(gp_pins), .irq_out(irq), .rx_ready_out(rdy));
   host_port_model host (.clk_in(ref_clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
      .reg_rd_out(rd), .reg_wdata_out(wdata));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict();
      if (n_errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   // Monitor: a missing note compares against unknown and so always fails.
   always @(posedge ref_clk_in) begin
      if (rvalid === 1'b1) begin
         chk(rdata, rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx);
      end
      if (chg) begin
         chk({4'h0, gp_pins, ser}, ser_q.size() > 0 ? ser_q.pop_front() : 8'hxx);
      end
      chg <= ofc !== ofc_q;
      ofc_q <= ofc;
   end
   task automatic send_bit(input logic v, input logic chb, input logic st);
      @(posedge ref_clk_in);
      rx_valid <= 1'b1;
      rx_bit <= v;
      rx_b <= chb;
      rx_start <= st;
      @(posedge ref_clk_in);
      rx_valid <= 1'b0;
   endtask : send_bit
   // Random frames; only frames 0..39 land in the image, MSB first.
   task automatic send_block(input int n, output logic [9:0][7:0] img);
      logic [31:0] r;
      for (int f = 0; f < n; f++) begin
         r = xs();
         if (f < 40) begin
            img[f / 8][7 - f % 8] = r[0];
            img[5 + f / 8][7 - f % 8] = r[1];
         end
         send_bit(r[0], 1'b0, f == 0);
         send_bit(r[1], 1'b1, 1'b0);
      end
   endtask : send_block
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      rd_q.push_back(e);
      host.rd(a);
   endtask : rd_chk
   task automatic read_img(input logic [9:0][7:0] img);
      for (int i = 0; i < BUF_BYTES; i++) begin
         rd_chk(7'(ADDR_STATUS_FIRST + i), img[i]);
      end
   endtask : read_img
   task automatic toggle(input logic [7:0] e);
      ser_q.push_back(e);
      @(posedge ref_clk_in);
      ofc <= ~ofc;
      @(posedge ref_clk_in);
   endtask : toggle
   // Hang guard.
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      n_errors++;
      give_verdict();
   end
   // Main sequence.
   initial begin
      {hw_mode, rx_valid, rx_bit, rx_b, rx_start, ofc, chg, ofc_q, rst_n_in} = 9'h100;
      seed = 32'd31571;
      repeat (12) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      // Overfill the stream buffer, then drain it and run one pop past empty.
      for (int i = 0; i < 20; i++) begin
         rnd = xs();
         if (i < 16) fbits[i] = rnd[0];
         send_bit(rnd[0], i[0], 1'b0);
      end
      for (int i = 0; i < 17; i++) toggle({7'h00, fbits[i < 16 ? i : 15]});
      // Software mode: each route value, then one popped bit.
      @(posedge ref_clk_in);
      hw_mode <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         host.wr(ADDR_PIN_ROUTE, 8'(r));
         rnd = xs();
         b = rnd[0];
         send_bit(b, 1'b0, 1'b0);
         toggle(r == 0 ? 8'h00 : 8'(b) << r);
      end
      host.wr(ADDR_SECOND_CONTROL, 8'h5a);
      rd_chk(ADDR_SECOND_CONTROL, 8'h5a);
      host.wr(ADDR_INT_ENABLE, 8'h01);
      send_block(192, img1);
      chk({7'h00, irq}, 8'h01);
      host.wr(ADDR_STATUS_FIRST, 8'hff);
      read_img(img1);
      rd_chk(ADDR_INT_STATUS, 8'h01);
      rd_chk(ADDR_INT_STATUS, 8'h00);
      // Inhibited block leaves the host copy and the flag alone.
      host.wr(ADDR_SECOND_CONTROL, 8'hda);
      send_block(192, img2);
      chk({7'h00, irq}, 8'h00);
      rd_chk(ADDR_INT_STATUS, 8'h00);
      read_img(img1);
      // Aborted partial block, then a whole one after the inhibit is lifted.
      host.wr(ADDR_SECOND_CONTROL, 8'h5a);
      send_block(20, junk);
      send_block(192, img2);
      read_img(img2);
      rd_chk(ADDR_INT_STATUS, 8'h01);
      repeat (4) @(posedge ref_clk_in);
      if (rd_q.size() != 0 || ser_q.size() != 0) n_errors++;
      give_verdict();
   end
endmodule : channel_status_buffer_test
